/* hw/srt_access_decode.sv */
`timescale 1ns/1ns
`default_nettype none
module srt_access_decode import srt_pkg::*; (
	input wire logic req_pair,
	input wire logic [3:0] req_crn,
	input wire logic [2:0] req_opc1,
	input wire logic [3:0] req_crm,
	input wire logic [2:0] req_opc2,
	output var srt_reg_t reg_id
);
	wire l1_c12 = !req_pair && req_crn == CRN_C12 && req_opc1 == OPC1_L1;
	wire pair_c12 = req_pair && req_crm == CRM_C12;
	// sgi registers only exist on the pair path; a single transfer there is unmapped
	wire hit_sgi0 = pair_c12 && req_opc1 == OPC1_SGI0;
	wire hit_sgi1 = pair_c12 && req_opc1 == OPC1_SGI1;
	wire hit_asgi1 = pair_c12 && req_opc1 == OPC1_ASGI1;
	wire hit_ctlr = l1_c12 && req_crm == CRM_C12 && req_opc2 == OPC2_CTLR;
	wire hit_dir = l1_c12 && req_crm == CRM_C11 && req_opc2 == OPC2_DIR;
	wire hit_rpr = l1_c12 && req_crm == CRM_C11 && req_opc2 == OPC2_RPR;
	wire hit_pmr = !req_pair && req_crn == CRN_C4 && req_opc1 == OPC1_L1 && req_crm == CRM_C6
		&& req_opc2 == OPC2_PMR;
	wire hit_sre1 = l1_c12 && req_crm == CRM_C12 && req_opc2 == OPC2_SRE;
	wire hit_sre2 = !req_pair && req_crn == CRN_C12 && req_opc1 == OPC1_L2 && req_crm == CRM_C9
		&& req_opc2 == OPC2_SRE;
	wire hit_sre3 = !req_pair && req_crn == CRN_C12 && req_opc1 == OPC1_L3 && req_crm == CRM_C12
		&& req_opc2 == OPC2_SRE;
	wire hit_other = l1_c12 && (req_crm == CRM_C8 || req_crm == CRM_C9 || req_crm == CRM_C12)
		&& !hit_ctlr && !hit_sre1;

	assign reg_id = hit_sgi0 ? REG_SGI0 :
		hit_sgi1 ? REG_SGI1 :
		hit_asgi1 ? REG_ASGI1 :
		hit_ctlr ? REG_CTLR :
		hit_dir ? REG_DIR :
		hit_rpr ? REG_RPR :
		hit_pmr ? REG_PMR :
		hit_sre1 ? REG_SRE1 :
		hit_sre2 ? REG_SRE2 :
		hit_sre3 ? REG_SRE3 :
		hit_other ? REG_OTHER : REG_NONE;
endmodule : srt_access_decode
`default_nettype wire

/* hw/srt_pkg.sv */
// Function
// - SGI generation registers are write-only, reached by 64-bit pair transfer, CRm c12, opc1 2/0/1.
// - level-3 register-interface enable may be hard-wired read-as-one, writes ignored.
// - level-2 enable may be hard-wired only if level-3 enable is hard-wired.
// - non-secure level-1 enable may be hard-wired only if level-2 enable is hard-wired.
// - secure level-1 enable may be hard-wired only if level-3 and level-2 are hard-wired.
// - SGI, control, deactivate, priority mask and running priority registers are common registers.
// - with common trap set, non-secure level-1 common register accesses trap to level 2.
// - with deactivate trap set, non-secure level-1 deactivate writes trap to level 2.
// - with either override set, non-secure level-1 accesses go virtual; virtual SGI accesses trap.
// - otherwise common registers reachable at level 1 or 2 by route, state and override.
// - non-secure level-1 enable reads zero, ignores writes unless level-2 and level-3 enabled.
// - level-2 lower-access enable clear traps non-secure level-1 enable register accesses to level 2.
// - level-3 lower-access enable clear traps non-secure level-1 enable register accesses to level 3.
// - secure level-1 enable reads zero, ignores writes while level-3 enable is zero.
// - level-3 lower-access enable clear traps secure level-1 enable register accesses to level 3.
// - level-2 enable reads zero, ignores writes while level-3 enable is zero.
// - level-2 enable zero makes level-2 lower-access enable act as one.
// - level-3 lower-access enable clear traps level-2 enable register accesses to level 3.
// - level-3 enable zero makes level-3 lower-access enable act as one.
// - a trap to level 3 becomes undefined at current level when level 3 runs 32-bit.
`default_nettype none
package srt_pkg;
	localparam logic [3:0] CRN_C4 = 4'h4;
	localparam logic [3:0] CRN_C12 = 4'hc;
	localparam logic [3:0] CRM_C6 = 4'h6;
	localparam logic [3:0] CRM_C8 = 4'h8;
	localparam logic [3:0] CRM_C9 = 4'h9;
	localparam logic [3:0] CRM_C11 = 4'hb;
	localparam logic [3:0] CRM_C12 = 4'hc;
	localparam logic [2:0] OPC1_L1 = 3'h0;
	localparam logic [2:0] OPC1_L2 = 3'h4;
	localparam logic [2:0] OPC1_L3 = 3'h6;
	localparam logic [2:0] OPC1_SGI0 = 3'h2;
	localparam logic [2:0] OPC1_SGI1 = 3'h0;
	localparam logic [2:0] OPC1_ASGI1 = 3'h1;
	localparam logic [2:0] OPC2_PMR = 3'h0;
	localparam logic [2:0] OPC2_DIR = 3'h1;
	localparam logic [2:0] OPC2_RPR = 3'h3;
	localparam logic [2:0] OPC2_CTLR = 3'h4;
	localparam logic [2:0] OPC2_SRE = 3'h5;
	localparam logic [1:0] LVL_1 = 2'h1;
	localparam logic [1:0] LVL_2 = 2'h2;
	localparam logic [1:0] LVL_3 = 2'h3;
	localparam int SRE_BIT = 0;
	localparam int SRE_EN_BIT = 3;
	localparam logic SRE_RST = 1'b0;
	localparam logic EN_RST = 1'b0;
	localparam logic [7:0] ADDR_CFG = 8'h00;
	localparam logic [7:0] ADDR_ROUTE = 8'h04;
	localparam logic [7:0] ADDR_HYP = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_ENABLES = 8'h10;
	localparam int CFG_EL3_A32 = 0;
	localparam int RT_NS = 0;
	localparam int RT_FIQ = 1;
	localparam int RT_IRQ = 2;
	localparam int RT_FMO = 3;
	localparam int RT_IMO = 4;
	localparam int HY_TC = 0;
	localparam int HY_DEACTIVATE_WRITE_TRAP = 1;
	localparam logic [7:0] TRAP_CNT_MAX = 8'hff;
	typedef enum logic [3:0] {
		REG_NONE = 4'h0, REG_SGI0 = 4'h1, REG_SGI1 = 4'h2, REG_ASGI1 = 4'h3, REG_CTLR = 4'h4,
		REG_DIR = 4'h5, REG_PMR = 4'h6, REG_RPR = 4'h7, REG_SRE1 = 4'h8, REG_SRE2 = 4'h9,
		REG_SRE3 = 4'ha, REG_OTHER = 4'hb
	} srt_reg_t;
	typedef enum logic [2:0] {
		OUT_PHYS = 3'h0, OUT_VIRT = 3'h1, OUT_TRAP_L2 = 3'h2, OUT_TRAP_L3 = 3'h3, OUT_UNDEF = 3'h4
	} srt_outcome_t;
endpackage : srt_pkg
`default_nettype wire

/* hw/srt_sre_bank.sv */
`timescale 1ns/1ns
`default_nettype none
module srt_sre_bank import srt_pkg::*; #(
	parameter bit HW_L3 = 1'b0,
	parameter bit HW_L2 = 1'b0,
	parameter bit HW_L1NS = 1'b0,
	parameter bit HW_L1S = 1'b0
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic wr_l3,
	input wire logic wr_l2,
	input wire logic wr_l1s,
	input wire logic wr_l1ns,
	input wire logic [31:0] wdata,
	output logic l3_sre_eff,
	output logic l3_en_q,
	output logic l3_en_eff,
	output logic l2_sre_eff,
	output logic l2_en_q,
	output logic l2_en_eff,
	output logic l1s_sre_eff,
	output logic l1ns_sre_eff
);
	logic l3_sre_reg, l3_en_reg, l2_sre_reg, l2_en_reg, l1s_sre_reg, l1ns_sre_reg;

	// an option whose prerequisite is not hard-wired is dropped rather than honoured
	wire hw3 = HW_L3;
	wire hw2 = HW_L2 && HW_L3;
	wire hw1ns = HW_L1NS && hw2;
	wire hw1s = HW_L1S && HW_L3 && HW_L2;

	assign l3_sre_eff = hw3 || l3_sre_reg;
	assign l2_sre_eff = l3_sre_eff && (hw2 || l2_sre_reg);
	assign l1s_sre_eff = l3_sre_eff && (hw1s || l1s_sre_reg);
	assign l1ns_sre_eff = l3_sre_eff && l2_sre_eff && (hw1ns || l1ns_sre_reg);
	assign l3_en_q = l3_en_reg;
	assign l2_en_q = l2_en_reg;
	assign l3_en_eff = l3_en_reg || !l3_sre_eff;
	assign l2_en_eff = l2_en_reg || !l2_sre_eff;

	// while a bit reads as zero its stored copy keeps the value it had
	wire l3_sre_we = wr_l3 && !hw3;
	wire l2_sre_we = wr_l2 && !hw2 && l3_sre_eff;
	wire l1s_sre_we = wr_l1s && !hw1s && l3_sre_eff;
	wire l1ns_sre_we = wr_l1ns && !hw1ns && l3_sre_eff && l2_sre_eff;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			l3_sre_reg <= SRE_RST;
			l3_en_reg <= EN_RST;
			l2_sre_reg <= SRE_RST;
			l2_en_reg <= EN_RST;
			l1s_sre_reg <= SRE_RST;
			l1ns_sre_reg <= SRE_RST;
		end else begin
			if (l3_sre_we) l3_sre_reg <= wdata[SRE_BIT];
			if (wr_l3) l3_en_reg <= wdata[SRE_EN_BIT];
			if (l2_sre_we) l2_sre_reg <= wdata[SRE_BIT];
			if (wr_l2) l2_en_reg <= wdata[SRE_EN_BIT];
			if (l1s_sre_we) l1s_sre_reg <= wdata[SRE_BIT];
			if (l1ns_sre_we) l1ns_sre_reg <= wdata[SRE_BIT];
		end
	end

	AST_L2_WI: assert property (@(posedge sys_clk) disable iff (!rstn)
		(wr_l2 && !l3_sre_eff) |=> (l2_sre_reg == $past(l2_sre_reg)))
		else $error("level-2 enable took a write while level-3 enable was zero");
	AST_L1S_RAZ: assert property (@(posedge sys_clk) disable iff (!rstn)
		!l3_sre_eff |-> !l1s_sre_eff)
		else $error("secure level-1 enable not read as zero");
	AST_L2_EN_FORCED: assert property (@(posedge sys_clk) disable iff (!rstn)
		(!l2_sre_eff && !l2_en_reg) |-> l2_en_eff)
		else $error("level-2 lower enable not forced while level-2 enable zero");
	AST_L3_EN_FORCED: assert property (@(posedge sys_clk) disable iff (!rstn)
		(!l3_sre_eff && !l3_en_reg) |-> (l3_en_eff && !l2_sre_eff))
		else $error("level-3 lower enable not forced while level-3 enable zero");
	AST_L3_HARDWIRED: assert property (@(posedge sys_clk) disable iff (!rstn)
		(wr_l3 && !wdata[SRE_BIT] && HW_L3) |=> l3_sre_eff)
		else $error("hard-wired level-3 enable cleared by a write");
endmodule : srt_sre_bank
`default_nettype wire

/* hw/srt_trap_ctrl.sv */
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module srt_trap_ctrl import srt_pkg::*; #(
	parameter bit HW_L3 = 1'b0,
	parameter bit HW_L2 = 1'b0,
	parameter bit HW_L1NS = 1'b0,
	parameter bit HW_L1S = 1'b0
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [7:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [31:0] bus_rdata,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic req_pair,
	input wire logic [1:0] req_level,
	input wire logic [3:0] req_crn,
	input wire logic [2:0] req_opc1,
	input wire logic [3:0] req_crm,
	input wire logic [2:0] req_opc2,
	input wire logic [31:0] req_wdata,
	output logic resp_valid,
	output logic [2:0] resp_outcome,
	output logic [31:0] resp_rdata
);
	function automatic logic [31:0] sre_word(input logic sre, input logic en);
		logic [31:0] w;
		w = '0;
		w[SRE_BIT] = sre;
		w[SRE_EN_BIT] = en;
		return w;
	endfunction : sre_word

	logic cfg_reg;
	logic [4:0] route_reg;
	logic [1:0] hyp_reg;
	logic [7:0] trap_cnt_reg;
	srt_outcome_t last_out_reg;
	logic [31:0] bus_rdata_reg;
	logic resp_valid_reg;
	srt_outcome_t resp_outcome_reg;
	logic [31:0] resp_rdata_reg;
	srt_reg_t reg_id;
	logic l3_sre_eff, l3_en_q, l3_en_eff, l2_sre_eff, l2_en_q, l2_en_eff, l1s_sre_eff, l1ns_sre_eff;

	srt_access_decode u_decode (
		.req_pair(req_pair),
		.req_crn(req_crn),
		.req_opc1(req_opc1),
		.req_crm(req_crm),
		.req_opc2(req_opc2),
		.reg_id(reg_id)
	);

	// routing and trap controls
	wire el3_a32 = cfg_reg;
	wire ns = route_reg[RT_NS];
	wire fiq_route = route_reg[RT_FIQ];
	wire irq_route = route_reg[RT_IRQ];
	wire fast_irq_virt_override = route_reg[RT_FMO];
	wire normal_irq_virt_override = route_reg[RT_IMO];
	wire tc = hyp_reg[HY_TC];
	wire deactivate_write_trap = hyp_reg[HY_DEACTIVATE_WRITE_TRAP];
	wire ovr = fast_irq_virt_override || normal_irq_virt_override;

	wire lvl1 = req_level == LVL_1;
	wire lvl2 = req_level == LVL_2;
	wire lvl3 = req_level == LVL_3;
	wire l1ns = lvl1 && ns;

	wire is_sgi = reg_id == REG_SGI0 || reg_id == REG_SGI1 || reg_id == REG_ASGI1;
	wire is_common = is_sgi || reg_id == REG_CTLR || reg_id == REG_DIR || reg_id == REG_PMR
		|| reg_id == REG_RPR;
	wire is_sre = reg_id == REG_SRE1 || reg_id == REG_SRE2 || reg_id == REG_SRE3;
	wire dir_wr = reg_id == REG_DIR && req_write;

	// wrong direction on a one-way register, or no register at all
	wire bad_dir = (is_sgi && !req_write) || (reg_id == REG_DIR && !req_write)
		|| (reg_id == REG_RPR && req_write) || reg_id == REG_NONE;

	// level 2 is reached only in non-secure state, so it reads the non-secure copy
	wire sre1_ns_sel = lvl2 || ns;
	wire cur_sre = lvl3 ? l3_sre_eff : lvl2 ? l2_sre_eff : ns ? l1ns_sre_eff : l1s_sre_eff;

	wire route_low = !fiq_route || !irq_route;
	wire common_ok_l1 = route_low && (!ns || !fast_irq_virt_override || !normal_irq_virt_override);
	wire common_ok_l2 = route_low && ns;

	// a 32-bit level 3 cannot take the trap, so the fault stays at the current level
	wire srt_outcome_t t3_out = el3_a32 ? OUT_UNDEF : OUT_TRAP_L3;

	wire srt_outcome_t icc_out =
		bad_dir ? OUT_UNDEF :
		!cur_sre ? OUT_UNDEF :
		lvl3 ? OUT_PHYS :
		(l1ns && is_common && tc) ? OUT_TRAP_L2 :
		(l1ns && dir_wr && deactivate_write_trap) ? OUT_TRAP_L2 :
		(l1ns && ovr && is_sgi) ? OUT_TRAP_L2 :
		(l1ns && ovr) ? OUT_VIRT :
		(is_common && lvl1 && !common_ok_l1) ? t3_out :
		(is_common && lvl2 && !common_ok_l2) ? t3_out : OUT_PHYS;

	wire srt_outcome_t sre3_out = lvl3 ? OUT_PHYS : OUT_UNDEF;
	wire srt_outcome_t sre2_out =
		lvl3 ? OUT_PHYS :
		!lvl2 ? OUT_UNDEF :
		!l3_en_eff ? t3_out : OUT_PHYS;
	wire srt_outcome_t sre1_out =
		lvl3 ? OUT_PHYS :
		(l1ns && !l2_en_eff) ? OUT_TRAP_L2 :
		(l1ns && !l3_en_eff) ? t3_out :
		(lvl1 && !ns && !l3_en_eff) ? t3_out :
		(lvl2 && !l3_en_eff) ? t3_out : OUT_PHYS;

	// enable registers are exempt from the virtual redirect
	wire srt_outcome_t outcome =
		reg_id == REG_SRE3 ? sre3_out :
		reg_id == REG_SRE2 ? sre2_out :
		reg_id == REG_SRE1 ? sre1_out : icc_out;

	wire sre_wr = req_valid && req_write && outcome == OUT_PHYS;
	wire wr_l3 = sre_wr && reg_id == REG_SRE3;
	wire wr_l2 = sre_wr && reg_id == REG_SRE2;
	wire wr_l1ns = sre_wr && reg_id == REG_SRE1 && sre1_ns_sel;
	wire wr_l1s = sre_wr && reg_id == REG_SRE1 && !sre1_ns_sel;

	srt_sre_bank #(
		.HW_L3(HW_L3),
		.HW_L2(HW_L2),
		.HW_L1NS(HW_L1NS),
		.HW_L1S(HW_L1S)
	) u_bank (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.wr_l3(wr_l3),
		.wr_l2(wr_l2),
		.wr_l1s(wr_l1s),
		.wr_l1ns(wr_l1ns),
		.wdata(req_wdata),
		.l3_sre_eff(l3_sre_eff),
		.l3_en_q(l3_en_q),
		.l3_en_eff(l3_en_eff),
		.l2_sre_eff(l2_sre_eff),
		.l2_en_q(l2_en_q),
		.l2_en_eff(l2_en_eff),
		.l1s_sre_eff(l1s_sre_eff),
		.l1ns_sre_eff(l1ns_sre_eff)
	);

	// forced enable bits read back their stored value, not the forced one
	wire [31:0] sre_rdata =
		reg_id == REG_SRE3 ? sre_word(l3_sre_eff, l3_en_q) :
		reg_id == REG_SRE2 ? sre_word(l2_sre_eff, l2_en_q) :
		sre1_ns_sel ? sre_word(l1ns_sre_eff, 1'b0) : sre_word(l1s_sre_eff, 1'b0);
	// other register contents live downstream; only enable reads carry data here
	wire [31:0] resp_rdata_next = (is_sre && !req_write && outcome == OUT_PHYS) ? sre_rdata : '0;

	wire is_trap = outcome == OUT_TRAP_L2 || outcome == OUT_TRAP_L3;
	wire trap_ev = req_valid && is_trap;
	wire st_clr = bus_wr && bus_addr == ADDR_STATUS;
	wire [7:0] trap_cnt_inc = (trap_cnt_reg == TRAP_CNT_MAX) ? trap_cnt_reg : trap_cnt_reg + 8'h01;
	// a trap landing with the clear still counts
	wire [7:0] trap_cnt_next = trap_ev ? (st_clr ? 8'h01 : trap_cnt_inc) : (st_clr ? 8'h00 : trap_cnt_reg);

	wire [31:0] status_word = {16'h0000, trap_cnt_reg, 5'h00, last_out_reg};
	wire [31:0] enables_word = {26'h0000000, l1ns_sre_eff, l1s_sre_eff, l2_en_eff, l2_sre_eff,
		l3_en_eff, l3_sre_eff};
	wire [31:0] bus_rdata_next =
		!bus_rd ? 32'h00000000 :
		bus_addr == ADDR_CFG ? {31'h00000000, cfg_reg} :
		bus_addr == ADDR_ROUTE ? {27'h0000000, route_reg} :
		bus_addr == ADDR_HYP ? {30'h00000000, hyp_reg} :
		bus_addr == ADDR_STATUS ? status_word :
		bus_addr == ADDR_ENABLES ? enables_word : 32'h00000000;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cfg_reg <= 1'b0;
			route_reg <= 5'h00;
			hyp_reg <= 2'h0;
		end else if (bus_wr) begin
			if (bus_addr == ADDR_CFG) cfg_reg <= bus_wdata[CFG_EL3_A32];
			if (bus_addr == ADDR_ROUTE) route_reg <= bus_wdata[4:0];
			if (bus_addr == ADDR_HYP) hyp_reg <= bus_wdata[1:0];
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			trap_cnt_reg <= 8'h00;
			last_out_reg <= OUT_PHYS;
			bus_rdata_reg <= 32'h00000000;
		end else begin
			trap_cnt_reg <= trap_cnt_next;
			if (req_valid) last_out_reg <= outcome;
			bus_rdata_reg <= bus_rdata_next;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			resp_valid_reg <= 1'b0;
			resp_outcome_reg <= OUT_PHYS;
			resp_rdata_reg <= 32'h00000000;
		end else begin
			resp_valid_reg <= req_valid;
			resp_outcome_reg <= req_valid ? outcome : OUT_PHYS;
			resp_rdata_reg <= req_valid ? resp_rdata_next : 32'h00000000;
		end
	end

	assign bus_rdata = bus_rdata_reg;
	assign resp_valid = resp_valid_reg;
	assign resp_outcome = resp_outcome_reg;
	assign resp_rdata = resp_rdata_reg;

	AST_SGI_READ_UNDEF: assert property (@(posedge sys_clk) disable iff (!rstn)
		(req_valid && is_sgi && !req_write) |=> (resp_valid && resp_outcome == OUT_UNDEF))
		else $error("read of an sgi register not refused");
	AST_COMMON_TRAP: assert property (@(posedge sys_clk) disable iff (!rstn)
		(req_valid && l1ns && is_common && tc && cur_sre && !bad_dir) |=> (resp_outcome == OUT_TRAP_L2))
		else $error("common register access not trapped to level 2");
	AST_DIR_TRAP: assert property (@(posedge sys_clk) disable iff (!rstn)
		(req_valid && l1ns && dir_wr && deactivate_write_trap && cur_sre) |=> (resp_outcome == OUT_TRAP_L2))
		else $error("deactivate write not trapped to level 2");
	AST_VIRT_REDIRECT: assert property (@(posedge sys_clk) disable iff (!rstn)
		(req_valid && l1ns && ovr && cur_sre && (reg_id == REG_OTHER || (reg_id == REG_PMR && !tc)))
		|=> (resp_valid && resp_outcome == OUT_VIRT))
		else $error("overridden access not redirected to virtual registers");
	AST_VIRT_SGI_TRAP: assert property (@(posedge sys_clk) disable iff (!rstn)
		(req_valid && l1ns && ovr && is_sgi && req_write && cur_sre) |=> (resp_outcome == OUT_TRAP_L2))
		else $error("virtual sgi access not trapped to level 2");
	AST_COMMON_ROUTE_HIGH: assert property (@(posedge sys_clk) disable iff (!rstn)
		(req_valid && lvl1 && !ns && reg_id == REG_PMR && cur_sre && fiq_route && irq_route)
		|=> (resp_outcome == ($past(el3_a32) ? OUT_UNDEF : OUT_TRAP_L3)))
		else $error("common register reached with both routes high");
	// checked on the core read path, not on the word that the bank builds
	AST_L1NS_RAZ: assert property (@(posedge sys_clk) disable iff (!rstn)
		(req_valid && reg_id == REG_SRE1 && sre1_ns_sel && !req_write && !(l3_sre_eff && l2_sre_eff))
		|=> !resp_rdata[SRE_BIT])
		else $error("non-secure level-1 enable not read as zero");
	AST_L1NS_TRAP_L2: assert property (@(posedge sys_clk) disable iff (!rstn)
		(req_valid && l1ns && reg_id == REG_SRE1 && !l2_en_eff) |=> (resp_outcome == OUT_TRAP_L2))
		else $error("non-secure level-1 enable access not trapped to level 2");
	AST_L1NS_TRAP_L3: assert property (@(posedge sys_clk) disable iff (!rstn)
		(req_valid && l1ns && reg_id == REG_SRE1 && l2_en_eff && !l3_en_eff && !el3_a32)
		|=> (resp_outcome == OUT_TRAP_L3))
		else $error("non-secure level-1 enable access not trapped to level 3");
	AST_L1S_TRAP_L3: assert property (@(posedge sys_clk) disable iff (!rstn)
		(req_valid && lvl1 && !ns && reg_id == REG_SRE1 && !l3_en_eff && !el3_a32)
		|=> (resp_outcome == OUT_TRAP_L3))
		else $error("secure level-1 enable access not trapped to level 3");
	AST_L2_TRAP_L3: assert property (@(posedge sys_clk) disable iff (!rstn)
		(req_valid && lvl2 && reg_id == REG_SRE2 && !l3_en_eff && !el3_a32) |=> (resp_outcome == OUT_TRAP_L3))
		else $error("level-2 enable access not trapped to level 3");
	AST_A32_NO_L3_TRAP: assert property (@(posedge sys_clk) disable iff (!rstn)
		(req_valid && el3_a32) |=> (resp_outcome != OUT_TRAP_L3))
		else $error("trap to a 32-bit level 3 not turned into undefined");
endmodule : srt_trap_ctrl
`default_nettype wire

/* test/srt_core_model.sv */
`timescale 1ns/1ns
`default_nettype none
module srt_core_model (
	input wire logic sys_clk,
	output logic req_valid,
	output logic req_write,
	output logic req_pair,
	output logic [1:0] req_level,
	output logic [3:0] req_crn,
	output logic [2:0] req_opc1,
	output logic [3:0] req_crm,
	output logic [2:0] req_opc2,
	output logic [31:0] req_wdata,
	input wire logic resp_valid,
	input wire logic [2:0] resp_outcome,
	input wire logic [31:0] resp_rdata
);
	initial begin
		req_valid = 1'b0;
		{req_write, req_pair, req_level, req_crn, req_opc1, req_crm, req_opc2, req_wdata} = '0;
	end
	// sgi registers only ever leave as pair transfers; the caller picks the kind
	task automatic access(input logic [49:0] ins, output logic seen, output logic [2:0] oc, output logic [31:0] rd);
		@(posedge sys_clk);
		req_valid <= 1'b1;
		{req_write, req_pair, req_level, req_crn, req_opc1, req_crm, req_opc2, req_wdata} <= ins;
		@(posedge sys_clk);
		req_valid <= 1'b0;
		// idle qualifiers scrambled so stale fields cannot pass for a request
		{req_write, req_pair, req_level, req_crn, req_opc1, req_crm, req_opc2, req_wdata} <= ~ins;
		#1;
		seen = resp_valid;
		oc = resp_outcome;
		rd = resp_rdata;
	endtask : access
endmodule : srt_core_model
`default_nettype wire

/* test/srt_trap_ctrl_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module srt_trap_ctrl_tb import srt_pkg::*; ();
	localparam logic [1:0] RD = 2'h0;
	localparam logic [1:0] WR = 2'h2;
	localparam logic [1:0] PW = 2'h3;
	localparam logic [1:0] PR = 2'h1;
	localparam logic [13:0] E_SRE3 = {CRN_C12, OPC1_L3, CRM_C12, OPC2_SRE};
	localparam logic [13:0] E_SRE2 = {CRN_C12, OPC1_L2, CRM_C9, OPC2_SRE};
	localparam logic [13:0] E_SRE1 = {CRN_C12, OPC1_L1, CRM_C12, OPC2_SRE};
	localparam logic [13:0] E_PMR = {CRN_C4, OPC1_L1, CRM_C6, OPC2_PMR};
	localparam logic [13:0] E_DIR = {CRN_C12, OPC1_L1, CRM_C11, OPC2_DIR};
	localparam logic [13:0] E_RPR = {CRN_C12, OPC1_L1, CRM_C11, OPC2_RPR};
	localparam logic [13:0] E_CTLR = {CRN_C12, OPC1_L1, CRM_C12, OPC2_CTLR};
	localparam logic [13:0] E_SGI0 = {4'h0, OPC1_SGI0, CRM_C12, 3'h0};
	localparam logic [13:0] E_SGI1 = {4'h0, OPC1_SGI1, CRM_C12, 3'h0};
	localparam logic [13:0] E_ASGI1 = {4'h0, OPC1_ASGI1, CRM_C12, 3'h0};
	logic sys_clk, rstn, bus_wr, bus_rd, req_valid, req_write, req_pair, resp_valid;
	logic [7:0] bus_addr;
	logic [1:0] req_level;
	logic [3:0] req_crn, req_crm;
	logic [2:0] req_opc1, req_opc2, resp_outcome;
	logic [31:0] bus_wdata, bus_rdata, req_wdata, resp_rdata, rd;
	logic [31:0] bus_rdata_hw, rd_hw;
	int n_mismatch, num_checks;
	srt_trap_ctrl dut (.sys_clk(sys_clk), .rstn(rstn), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_rdata(bus_rdata), .req_valid(req_valid), .req_write(req_write), .req_pair(req_pair),
		.req_level(req_level), .req_crn(req_crn), .req_opc1(req_opc1), .req_crm(req_crm), .req_opc2(req_opc2),
		.req_wdata(req_wdata), .resp_valid(resp_valid), .resp_outcome(resp_outcome), .resp_rdata(resp_rdata));
	srt_core_model core (.sys_clk(sys_clk), .req_valid(req_valid), .req_write(req_write), .req_pair(req_pair),
		.req_level(req_level), .req_crn(req_crn), .req_opc1(req_opc1), .req_crm(req_crm), .req_opc2(req_opc2),
		.req_wdata(req_wdata), .resp_valid(resp_valid), .resp_outcome(resp_outcome), .resp_rdata(resp_rdata));
	// every enable hard-wired; shares all stimulus, only its enables are judged
	srt_trap_ctrl #(.HW_L3(1'b1), .HW_L2(1'b1), .HW_L1NS(1'b1), .HW_L1S(1'b1)) dut_hw (.sys_clk(sys_clk),
		.rstn(rstn), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_rdata(bus_rdata_hw), .req_valid(req_valid), .req_write(req_write), .req_pair(req_pair),
		.req_level(req_level), .req_crn(req_crn), .req_opc1(req_opc1), .req_crm(req_crm), .req_opc2(req_opc2),
		.req_wdata(req_wdata), .resp_valid(), .resp_outcome(), .resp_rdata());
	task automatic fail(input string m);
		n_mismatch++;
		$display("[FAIL] %0t %s", $time, m);
	endtask : fail
	task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) fail($sformatf("word %h expected %h", g, e));
	endtask : chk_word
	task automatic chk_out(input logic [2:0] g, input logic [2:0] e);
		num_checks++;
		if (g !== e) fail($sformatf("outcome %0d expected %0d", g, e));
	endtask : chk_out
	task automatic bw(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge sys_clk);
		bus_wr <= 1'b0;
		bus_wdata <= ~d;
	endtask : bw
	task automatic br(input logic [7:0] a);
		@(posedge sys_clk);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge sys_clk);
		bus_rd <= 1'b0;
		#1;
		rd = bus_rdata;
		rd_hw = bus_rdata_hw;
	endtask : br
	task automatic acc(input logic [1:0] k, input logic [1:0] lv, input logic [13:0] e, input logic [31:0] wd,
		input logic [2:0] ex);
		logic seen;
		logic [2:0] oc;
		core.access({k, lv, e, wd}, seen, oc, rd);
		chk_out({2'h0, seen}, 3'h1);
		chk_out(oc, ex);
	endtask : acc
	task automatic t_reset;
		br(ADDR_ENABLES);
		chk_word(rd, 32'h0000000a);
		br(8'h44);
		chk_word(rd, 32'h0);
		acc(RD, LVL_1, E_PMR, 32'h0, OUT_UNDEF);
		acc(WR, LVL_3, E_SRE1, 32'h1, OUT_PHYS);
		acc(WR, LVL_3, E_SRE2, 32'h9, OUT_PHYS);
		bw(ADDR_ROUTE, 32'h1);
		acc(WR, LVL_3, E_SRE1, 32'h1, OUT_PHYS);
		acc(RD, LVL_3, E_SRE1, 32'h0, OUT_PHYS);
		chk_word(rd, 32'h00000000);
		br(ADDR_ENABLES);
		chk_word(rd, 32'h0000000a);
		$display("t_reset done");
	endtask : t_reset
	task automatic t_chain;
		bw(ADDR_ROUTE, 32'h0);
		acc(WR, LVL_3, E_SRE3, 32'h1, OUT_PHYS);
		br(ADDR_ENABLES);
		chk_word(rd, 32'h00000009);
		bw(ADDR_ROUTE, 32'h1);
		acc(RD, LVL_2, E_SRE2, 32'h0, OUT_TRAP_L3);
		bw(ADDR_CFG, 32'h1);
		acc(RD, LVL_2, E_SRE2, 32'h0, OUT_UNDEF);
		bw(ADDR_CFG, 32'h0);
		acc(RD, LVL_1, E_SRE1, 32'h0, OUT_TRAP_L3);
		bw(ADDR_ROUTE, 32'h0);
		acc(RD, LVL_1, E_SRE1, 32'h0, OUT_TRAP_L3);
		acc(WR, LVL_3, E_SRE3, 32'h9, OUT_PHYS);
		acc(WR, LVL_3, E_SRE2, 32'h1, OUT_PHYS);
		br(ADDR_ENABLES);
		chk_word(rd, 32'h00000007);
		bw(ADDR_ROUTE, 32'h1);
		acc(RD, LVL_1, E_SRE1, 32'h0, OUT_TRAP_L2);
		acc(WR, LVL_2, E_SRE2, 32'h9, OUT_PHYS);
		acc(WR, LVL_1, E_SRE1, 32'h1, OUT_PHYS);
		acc(RD, LVL_1, E_SRE1, 32'h0, OUT_PHYS);
		chk_word(rd, 32'h00000001);
		bw(ADDR_ROUTE, 32'h0);
		// secure copy raised; it needs only the level-3 enable up, not the level-2 one
		acc(WR, LVL_3, E_SRE1, 32'h1, OUT_PHYS);
		br(ADDR_ENABLES);
		chk_word(rd, 32'h0000003f);
		$display("t_chain done");
	endtask : t_chain
	task automatic t_common;
		logic [13:0] enc [7];
		logic [1:0] kd [7];
		int i;
		enc = '{E_SGI0, E_SGI1, E_ASGI1, E_CTLR, E_DIR, E_PMR, E_RPR};
		kd = '{PW, PW, PW, RD, WR, RD, RD};
		bw(ADDR_ROUTE, 32'h1);
		for (i = 0; i < 7; i++) acc(kd[i], LVL_1, enc[i], 32'h0, OUT_PHYS);
		bw(ADDR_HYP, 32'h1);
		for (i = 0; i < 7; i++) acc(kd[i], LVL_1, enc[i], 32'h0, OUT_TRAP_L2);
		acc(RD, LVL_1, E_SRE1, 32'h0, OUT_PHYS);
		bw(ADDR_HYP, 32'h2);
		acc(WR, LVL_1, E_DIR, 32'h0, OUT_TRAP_L2);
		acc(RD, LVL_1, E_PMR, 32'h0, OUT_PHYS);
		bw(ADDR_HYP, 32'h0);
		acc(PR, LVL_1, E_SGI1, 32'h0, OUT_UNDEF);
		bw(ADDR_ROUTE, 32'h9);
		acc(RD, LVL_1, E_PMR, 32'h0, OUT_VIRT);
		acc(PW, LVL_1, E_SGI0, 32'h0, OUT_TRAP_L2);
		acc(RD, LVL_1, E_SRE1, 32'h0, OUT_PHYS);
		bw(ADDR_ROUTE, 32'h11);
		acc(RD, LVL_1, E_CTLR, 32'h0, OUT_VIRT);
		// one group virtual, one physical: run with the common trap set
		bw(ADDR_HYP, 32'h1);
		acc(RD, LVL_1, E_PMR, 32'h0, OUT_TRAP_L2);
		bw(ADDR_HYP, 32'h0);
		bw(ADDR_ROUTE, 32'h7);
		acc(RD, LVL_1, E_PMR, 32'h0, OUT_TRAP_L3);
		acc(RD, LVL_2, E_PMR, 32'h0, OUT_TRAP_L3);
		bw(ADDR_ROUTE, 32'h3);
		acc(RD, LVL_1, E_PMR, 32'h0, OUT_PHYS);
		acc(RD, LVL_2, E_PMR, 32'h0, OUT_PHYS);
		bw(ADDR_ROUTE, 32'h6);
		acc(RD, LVL_1, E_PMR, 32'h0, OUT_TRAP_L3);
		br(ADDR_ROUTE);
		chk_word(rd, 32'h00000006);
		// seventeen traps so far, the last one to level 3
		br(ADDR_STATUS);
		chk_word(rd, 32'h00001103);
		bw(ADDR_STATUS, 32'h0);
		br(ADDR_STATUS);
		chk_word(rd, 32'h00000003);
		$display("t_common done");
	endtask : t_common
	task automatic t_hard;
		acc(WR, LVL_3, E_SRE3, 32'h0, OUT_PHYS);
		acc(WR, LVL_3, E_SRE2, 32'h0, OUT_PHYS);
		acc(WR, LVL_3, E_SRE1, 32'h0, OUT_PHYS);
		bw(ADDR_ROUTE, 32'h1);
		acc(WR, LVL_3, E_SRE1, 32'h0, OUT_PHYS);
		br(ADDR_ENABLES);
		chk_word(rd_hw, 32'h00000035);
		chk_word(rd, 32'h0000000a);
		$display("t_hard done");
	endtask : t_hard
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		rstn = 1'b0;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		bus_addr = 8'h00;
		bus_wdata = 32'h0;
		n_mismatch = 0;
		num_checks = 0;
		repeat (8) @(posedge sys_clk);
		rstn <= 1'b1;
		t_reset();
		t_chain();
		t_common();
		t_hard();
		report_and_stop();
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		fail("watchdog expired");
		report_and_stop();
	end
endmodule : srt_trap_ctrl_tb
`default_nettype wire
